//--- design/priv_ops_pkg.sv
// Constants and types for the privileged, bit and pixel operation decoder
`default_nettype none
package priv_ops_pkg;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_LOAD_DEDICATED = 4'h1,
		OP_STORE_DEDICATED = 4'h2,
		OP_SET_STATUS = 4'h3,
		OP_CLEAR_STATUS = 4'h4,
		OP_SET_CONFIG = 4'h5,
		OP_DIAGNOSE = 4'h6,
		OP_ATOMIC_SET = 4'h7,
		OP_ATOMIC_CLEAR = 4'h8,
		OP_TEST_INVERT = 4'h9,
		OP_PIXEL_ADDR = 4'ha,
		OP_FLOAT_TRUNC = 4'hb,
		OP_FLOAT_FLOOR = 4'hc,
		OP_BLOCK_OPTS = 4'hd
	} op_t;
	typedef enum logic [3:0] {
		DREG_UPPER_SP = 4'h0,
		DREG_FRAME_PTR = 4'h8,
		DREG_USER_SP = 4'h9,
		DREG_STATUS = 4'hd,
		DREG_INT_BASE = 4'he,
		DREG_MODULE = 4'hf
	} dreg_t;
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_DOUBLE = 2'h3
	} size_t_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_EXEC = 6'h02,
		ST_RMW_READ = 6'h04,
		ST_RMW_WRITE = 6'h08,
		ST_PIXEL = 6'h10,
		ST_TRAP = 6'h20
	} state_t;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam int STATUS_USER_BIT = 8;
	localparam logic [15:0] STATUS_LOW_BYTE = 16'h00ff;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [31:0] INT_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] DIAGNOSE_LENGTH = 32'h0000_0000;
	localparam logic [31:0] INSTR_STEP = 32'h0000_0001;
	localparam int FLOAT_BIAS = 127;
	localparam int FLOAT_MANT_W = 23;
	localparam int FLOAT_EXP_LSB = 23;
	localparam int FLOAT_SIGN_BIT = 31;
	localparam logic [7:0] FLOAT_EXP_BIAS = 8'h7f;
	localparam logic [7:0] FLOAT_EXP_MAX = 8'h9e;
	localparam int BLOCK_OPT_W = 4;
	localparam int STATUS_BLOCK_LSB = 5;
endpackage : priv_ops_pkg
`default_nettype wire

//--- design/pixel_address_gen.sv
// Cartesian to linear bit address generator
`default_nettype none
module pixel_address_gen
	import priv_ops_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_start,
	input wire logic [31:0] i_origin_bit_address,
	input wire logic [31:0] i_pitch_bits,
	input wire logic [15:0] i_x,
	input wire logic [15:0] i_y,
	output logic o_done,
	output logic [31:0] o_bit_address
);
	logic [31:0] next_address;
	logic next_done;

	// Pitch counts bits, so no byte scaling is applied
	always_comb begin
		next_done = i_start;
		next_address = o_bit_address;
		if (i_start) begin
			next_address = i_origin_bit_address + 32'(i_y) * i_pitch_bits + 32'(i_x);
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_bit_address <= 32'h0000_0000;
			o_done <= 1'b0;
		end else begin
			o_bit_address <= next_address;
			o_done <= next_done;
		end
	end
endmodule : pixel_address_gen
`default_nettype wire

//--- design/float_to_int.sv
// Single precision float to integer conversion, truncate or floor
`default_nettype none
module float_to_int
	import priv_ops_pkg::*;
(
	input wire logic [31:0] i_value,
	input wire logic i_floor,
	output logic [31:0] o_result
);
	logic sign;
	logic [7:0] exponent;
	logic [55:0] mant;
	logic [55:0] shifted;
	logic fraction_lost;
	logic [31:0] magnitude;
	logic [7:0] shift;

	always_comb begin
		sign = i_value[FLOAT_SIGN_BIT];
		exponent = i_value[FLOAT_SIGN_BIT-1:FLOAT_EXP_LSB];
		mant = {32'h0000_0000, 1'b1, i_value[FLOAT_MANT_W-1:0]};
		shifted = 56'h0;
		fraction_lost = 1'b0;
		magnitude = 32'h0000_0000;
		shift = 8'h00;
		// Exponents above FLOAT_EXP_MAX saturate; no overflow trap here
		if (exponent < FLOAT_EXP_BIAS) begin
			fraction_lost = (i_value[FLOAT_SIGN_BIT-1:0] != 31'h0);
		end else if (exponent > FLOAT_EXP_MAX) begin
			magnitude = 32'h7fff_ffff;
		end else begin
			shift = exponent - FLOAT_EXP_BIAS;
			shifted = mant << shift;
			magnitude = shifted[FLOAT_MANT_W +: 32];
			fraction_lost = (shifted[FLOAT_MANT_W-1:0] != '0);
		end
		o_result = sign ? (32'h0 - magnitude) : magnitude;
		if (i_floor && sign && fraction_lost) begin
			o_result = o_result - 32'h0000_0001;
		end
	end
endmodule : float_to_int
`default_nettype wire

//--- design/priv_ops_core.sv
// Decode and execute for privileged, bit test and pixel address operations
`default_nettype none
module priv_ops_core
	import priv_ops_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_valid,
	input wire op_t i_op,
	input wire logic [3:0] i_dreg,
	input wire logic [1:0] i_size,
	input wire logic [31:0] i_operand,
	input wire logic [31:0] i_pc,
	input wire logic [4:0] i_bit_index,
	input wire logic [15:0] i_x,
	input wire logic [15:0] i_y,
	input wire logic [31:0] i_pitch_bits,
	input wire logic [3:0] i_block_field_opts,
	input wire logic [31:0] i_mem_rdata,
	input wire logic i_mem_ack,
	output logic o_busy,
	output logic o_done,
	output logic o_trap_illegal,
	output logic [15:0] o_status,
	output logic [7:0] o_config,
	output logic [31:0] o_int_base,
	output logic [31:0] o_result,
	output logic o_flag,
	output logic [31:0] o_next_pc,
	output logic o_mem_req,
	output logic o_mem_we,
	output logic o_mem_lock,
	output logic [31:0] o_mem_wdata,
	output logic [3:0] o_block_opts
);
	state_t state, next_state;
	op_t op, next_op;
	logic [3:0] dreg, next_dreg;
	logic [1:0] size, next_size;
	logic [31:0] operand, next_operand;
	logic [4:0] bit_index, next_bit_index;
	logic [15:0] next_status;
	logic [7:0] next_config;
	logic [31:0] next_int_base, next_result, next_next_pc, next_mem_wdata;
	logic next_busy, next_done, next_trap, next_flag;
	logic next_mem_req, next_mem_we, next_mem_lock;
	logic [3:0] next_block_opts;
	logic pix_done;
	logic [31:0] pix_address;
	logic [31:0] float_result;
	logic pix_start;
	// Operands latched at take so the issuer may move on while busy
	logic [31:0] taken_pc, next_taken_pc;
	logic [31:0] pitch, next_pitch;
	logic [15:0] pix_x, next_pix_x;
	logic [15:0] pix_y, next_pix_y;
	logic [3:0] field_opts, next_field_opts;

	function automatic logic needs_priv(input op_t o, input logic [3:0] d, input logic [1:0] s);
		logic sensitive;
		// Only the status and interrupt base codes are sensitive
		sensitive = (d == DREG_STATUS) || (d == DREG_INT_BASE);
		case (o)
			OP_LOAD_DEDICATED: needs_priv = sensitive;
			OP_STORE_DEDICATED: needs_priv = sensitive;
			OP_SET_STATUS: needs_priv = (s != SIZE_BYTE);
			OP_CLEAR_STATUS: needs_priv = (s != SIZE_BYTE);
			OP_SET_CONFIG: needs_priv = 1'b1;
			default: needs_priv = 1'b0;
		endcase
	endfunction : needs_priv

	// Byte sized status ops may only reach the low byte, so user code cannot leave user mode
	function automatic logic [15:0] size_mask(input logic [1:0] s);
		size_mask = (s == SIZE_BYTE) ? STATUS_LOW_BYTE : 16'hffff;
	endfunction : size_mask

	pixel_address_gen u_pixel (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_start(pix_start),
		.i_origin_bit_address(operand),
		.i_pitch_bits(pitch),
		.i_x(pix_x),
		.i_y(pix_y),
		.o_done(pix_done),
		.o_bit_address(pix_address)
	);

	float_to_int u_float (
		.i_value(operand),
		.i_floor(op == OP_FLOAT_FLOOR),
		.o_result(float_result)
	);

	assign pix_start = (state == ST_EXEC) && (op == OP_PIXEL_ADDR);

	always_comb begin
		next_state = state;
		next_op = op;
		next_dreg = dreg;
		next_size = size;
		next_operand = operand;
		next_bit_index = bit_index;
		next_status = o_status;
		next_config = o_config;
		next_int_base = o_int_base;
		next_result = o_result;
		next_next_pc = o_next_pc;
		next_mem_wdata = o_mem_wdata;
		next_busy = o_busy;
		next_done = 1'b0;
		next_trap = 1'b0;
		next_flag = o_flag;
		next_mem_req = 1'b0;
		next_mem_we = 1'b0;
		next_mem_lock = o_mem_lock;
		next_block_opts = o_block_opts;
		next_taken_pc = taken_pc;
		next_pitch = pitch;
		next_pix_x = pix_x;
		next_pix_y = pix_y;
		next_field_opts = field_opts;
		case (state)
			ST_IDLE: begin
				if (i_valid) begin
					next_op = i_op;
					next_dreg = i_dreg;
					next_size = i_size;
					next_operand = i_operand;
					next_bit_index = i_bit_index;
					// Coordinates and pitch frozen here, not read live in EXEC
					next_taken_pc = i_pc;
					next_pitch = i_pitch_bits;
					next_pix_x = i_x;
					next_pix_y = i_y;
					next_field_opts = i_block_field_opts;
					next_next_pc = i_pc + INSTR_STEP;
					next_busy = 1'b1;
					if (o_status[STATUS_USER_BIT] && needs_priv(i_op, i_dreg, i_size)) begin
						next_state = ST_TRAP;
					end else begin
						next_state = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				next_state = ST_IDLE;
				next_busy = 1'b0;
				next_done = 1'b1;
				case (op)
					OP_LOAD_DEDICATED: begin
						if (dreg == DREG_STATUS) begin
							next_status = operand[15:0];
						end else if (dreg == DREG_INT_BASE) begin
							next_int_base = operand;
						end
					end
					OP_STORE_DEDICATED: begin
						if (dreg == DREG_STATUS) begin
							next_result = {16'h0000, o_status};
						end else if (dreg == DREG_INT_BASE) begin
							next_result = o_int_base;
						end else begin
							next_result = 32'h0000_0000;
						end
					end
					OP_SET_STATUS: next_status = o_status | (operand[15:0] & size_mask(size));
					OP_CLEAR_STATUS: next_status = o_status & ~(operand[15:0] & size_mask(size));
					OP_SET_CONFIG: next_config = operand[7:0];
					// Pc stays put, so fetch spins on this one byte
					OP_DIAGNOSE: next_next_pc = taken_pc + DIAGNOSE_LENGTH;
					OP_ATOMIC_SET, OP_ATOMIC_CLEAR, OP_TEST_INVERT: begin
						next_state = ST_RMW_READ;
						next_busy = 1'b1;
						next_done = 1'b0;
						next_mem_req = 1'b1;
						// Plain invert leaves the bus unlocked
						next_mem_lock = (op != OP_TEST_INVERT);
					end
					OP_PIXEL_ADDR: begin
						next_state = ST_PIXEL;
						next_busy = 1'b1;
						next_done = 1'b0;
					end
					OP_FLOAT_TRUNC, OP_FLOAT_FLOOR: next_result = float_result;
					OP_BLOCK_OPTS: begin
						next_block_opts = field_opts
							| o_status[STATUS_BLOCK_LSB +: BLOCK_OPT_W]
							| operand[BLOCK_OPT_W-1:0];
					end
					default: next_result = o_result;
				endcase
			end
			ST_RMW_READ: begin
				if (i_mem_ack) begin
					next_flag = i_mem_rdata[bit_index];
					next_mem_wdata = i_mem_rdata;
					case (op)
						OP_ATOMIC_SET: next_mem_wdata[bit_index] = 1'b1;
						OP_ATOMIC_CLEAR: next_mem_wdata[bit_index] = 1'b0;
						default: next_mem_wdata[bit_index] = ~i_mem_rdata[bit_index];
					endcase
					next_mem_req = 1'b1;
					next_mem_we = 1'b1;
					next_state = ST_RMW_WRITE;
				end else begin
					next_mem_req = 1'b1;
				end
			end
			ST_RMW_WRITE: begin
				// For atomic set and clear, lock held across both halves so no other master slips in between
				if (i_mem_ack) begin
					next_mem_lock = 1'b0;
					next_busy = 1'b0;
					next_done = 1'b1;
					next_state = ST_IDLE;
				end else begin
					next_mem_req = 1'b1;
					next_mem_we = 1'b1;
				end
			end
			ST_PIXEL: begin
				// Generator answers one cycle after its start pulse
				if (pix_done) begin
					next_result = pix_address;
					next_busy = 1'b0;
					next_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_TRAP: begin
				// Trap skips EXEC, so the latched operand never reaches status, config or int base
				next_trap = 1'b1;
				next_busy = 1'b0;
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= ST_IDLE;
			op <= OP_NONE;
			dreg <= 4'h0;
			size <= 2'h0;
			operand <= 32'h0000_0000;
			bit_index <= 5'h00;
			o_status <= STATUS_RESET;
			o_config <= CONFIG_RESET;
			o_int_base <= INT_BASE_RESET;
			o_result <= 32'h0000_0000;
			o_next_pc <= 32'h0000_0000;
			o_mem_wdata <= 32'h0000_0000;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_trap_illegal <= 1'b0;
			o_flag <= 1'b0;
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_mem_lock <= 1'b0;
			o_block_opts <= 4'h0;
			taken_pc <= 32'h0000_0000;
			pitch <= 32'h0000_0000;
			pix_x <= 16'h0000;
			pix_y <= 16'h0000;
			field_opts <= 4'h0;
		end else begin
			state <= next_state;
			op <= next_op;
			dreg <= next_dreg;
			size <= next_size;
			operand <= next_operand;
			bit_index <= next_bit_index;
			o_status <= next_status;
			o_config <= next_config;
			o_int_base <= next_int_base;
			o_result <= next_result;
			o_next_pc <= next_next_pc;
			o_mem_wdata <= next_mem_wdata;
			o_busy <= next_busy;
			o_done <= next_done;
			o_trap_illegal <= next_trap;
			o_flag <= next_flag;
			o_mem_req <= next_mem_req;
			o_mem_we <= next_mem_we;
			o_mem_lock <= next_mem_lock;
			o_block_opts <= next_block_opts;
			taken_pc <= next_taken_pc;
			pitch <= next_pitch;
			pix_x <= next_pix_x;
			pix_y <= next_pix_y;
			field_opts <= next_field_opts;
		end
	end
endmodule : priv_ops_core
`default_nettype wire

//--- test/priv_ops_core_assertions.sv
// Checker for the privileged, bit and pixel operation core
`default_nettype none
module priv_ops_core_checker
	import priv_ops_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_valid,
	input wire op_t i_op,
	input wire logic [3:0] i_dreg,
	input wire logic [1:0] i_size,
	input wire logic [31:0] i_operand,
	input wire logic [31:0] i_pc,
	input wire logic [15:0] i_x,
	input wire logic [15:0] i_y,
	input wire logic [31:0] i_pitch_bits,
	input wire logic i_mem_ack,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_trap_illegal,
	input wire logic [15:0] o_status,
	input wire logic [7:0] o_config,
	input wire logic [31:0] o_next_pc,
	input wire logic [31:0] o_result,
	input wire logic o_mem_we,
	input wire logic o_mem_lock
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	wire logic tk = i_valid && !o_busy;
	wire logic usr = o_status[STATUS_USER_BIT];
	logic [31:0] cap;
	logic [31:0] next_cap;
	// Expected value captured at the taking edge, held while busy
	always_comb begin
		next_cap = cap;
		if (tk) begin
			case (i_op)
				OP_SET_STATUS: next_cap = {16'h0000, o_status | {8'h00, i_operand[7:0]}};
				OP_CLEAR_STATUS: next_cap = {16'h0000, o_status & ~{8'h00, i_operand[7:0]}};
				OP_DIAGNOSE: next_cap = i_pc;
				OP_PIXEL_ADDR: next_cap = i_operand + i_y * i_pitch_bits + {16'h0000, i_x};
				default: next_cap = cap;
			endcase
		end
	end
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) cap <= 32'h0000_0000;
		else cap <= next_cap;
	end
	dreg_user_trap_a: assert property (tk && usr && (i_op == OP_LOAD_DEDICATED ||
		i_op == OP_STORE_DEDICATED) && (i_dreg == DREG_STATUS || i_dreg == DREG_INT_BASE)
		|-> ##[1:3] o_trap_illegal) else $error("dedicated register access not trapped");
	size_user_trap_a: assert property (tk && usr && i_size != SIZE_BYTE &&
		(i_op == OP_SET_STATUS || i_op == OP_CLEAR_STATUS) |-> ##[1:3] o_trap_illegal)
		else $error("word status change not trapped");
	cfg_user_trap_a: assert property (tk && usr && i_op == OP_SET_CONFIG
		|-> ##[1:3] o_trap_illegal) else $error("config set not trapped");
	trap_keeps_state_a: assert property (o_trap_illegal |->
		!o_done && $stable(o_status) && $stable(o_config)) else $error("trap changed state");
	set_byte_or_a: assert property (tk && i_op == OP_SET_STATUS && i_size == SIZE_BYTE
		|-> ##[1:3] (o_done && o_status == cap[15:0])) else $error("status set wrong");
	clr_byte_and_a: assert property (tk && i_op == OP_CLEAR_STATUS && i_size == SIZE_BYTE
		|-> ##[1:3] (o_done && o_status == cap[15:0])) else $error("status clear wrong");
	diag_loop_a: assert property (tk && i_op == OP_DIAGNOSE
		|-> ##[1:3] (o_done && o_next_pc == cap)) else $error("diagnose did not loop");
	pixel_map_a: assert property (tk && i_op == OP_PIXEL_ADDR
		|-> ##[2:5] (o_done && o_result == cap)) else $error("pixel address wrong");
	lock_held_a: assert property (o_mem_lock && !(o_mem_we && i_mem_ack)
		|=> o_mem_lock) else $error("lock dropped inside access");
endmodule : priv_ops_core_checker
bind priv_ops_core priv_ops_core_checker chk (.i_clock(i_clock), .i_rstn(i_rstn),
	.i_valid(i_valid), .i_op(i_op), .i_dreg(i_dreg), .i_size(i_size), .i_operand(i_operand),
	.i_pc(i_pc), .i_x(i_x), .i_y(i_y), .i_pitch_bits(i_pitch_bits), .i_mem_ack(i_mem_ack),
	.o_busy(o_busy), .o_done(o_done), .o_trap_illegal(o_trap_illegal), .o_status(o_status),
	.o_config(o_config), .o_next_pc(o_next_pc), .o_result(o_result), .o_mem_we(o_mem_we),
	.o_mem_lock(o_mem_lock));
`default_nettype wire

//--- test/test_priv_ops_core.sv
// Testbench for the privileged, bit and pixel operation core
`default_nettype none
module test_priv_ops_core
	import priv_ops_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'h0, i_rstn = 1'h0, i_valid = 1'h0, i_mem_ack = 1'h0, lock_seen;
	op_t i_op = OP_NONE;
	logic [3:0] i_dreg = 4'h0, i_block_field_opts = 4'h0, o_block_opts;
	logic [1:0] i_size = 2'h0;
	logic [31:0] i_operand = 32'h0, i_pc = 32'h0000_0100, i_pitch_bits = 32'h0;
	logic [31:0] i_mem_rdata = 32'h0, wdata, o_int_base, o_result, o_next_pc, o_mem_wdata;
	logic [4:0] i_bit_index = 5'h0;
	logic [15:0] i_x = 16'h0, i_y = 16'h0, o_status;
	logic o_busy, o_done, o_trap_illegal, o_flag, o_mem_req, o_mem_we, o_mem_lock;
	logic [7:0] o_config;
	int fail_count = 0, compares = 0, cyc = 0;
	priv_ops_core dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_valid(i_valid), .i_op(i_op),
		.i_dreg(i_dreg), .i_size(i_size), .i_operand(i_operand), .i_pc(i_pc),
		.i_bit_index(i_bit_index), .i_x(i_x), .i_y(i_y), .i_pitch_bits(i_pitch_bits),
		.i_block_field_opts(i_block_field_opts), .i_mem_rdata(i_mem_rdata),
		.i_mem_ack(i_mem_ack), .o_busy(o_busy), .o_done(o_done),
		.o_trap_illegal(o_trap_illegal), .o_status(o_status), .o_config(o_config),
		.o_int_base(o_int_base), .o_result(o_result), .o_flag(o_flag), .o_next_pc(o_next_pc),
		.o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_lock(o_mem_lock),
		.o_mem_wdata(o_mem_wdata), .o_block_opts(o_block_opts));
	always #50 i_clock = ~i_clock;
	// Memory answers each request one cycle late, so every access sees a wait
	always @(posedge i_clock) begin
		i_mem_ack <= o_mem_req && !i_mem_ack;
		if (o_mem_req && o_mem_we && i_mem_ack) wdata <= o_mem_wdata;
		if (o_mem_lock) lock_seen <= 1'h1;
		else if (i_valid && !o_busy) lock_seen <= 1'h0;
	end
	task end_of_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			end_of_test();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task reset;
		i_rstn <= 1'h0;
		repeat (20) @(posedge i_clock);
		i_rstn <= 1'h1;
	endtask : reset
	task run(input op_t op, input logic [3:0] dr, input logic [1:0] sz, input logic [31:0] v,
		input logic tr);
		logic d;
		logic t;
		d = 1'h0;
		t = 1'h0;
		@(posedge i_clock);
		i_op <= op;
		i_dreg <= dr;
		i_size <= sz;
		i_operand <= v;
		i_valid <= 1'h1;
		@(posedge i_clock);
		i_valid <= 1'h0;
		for (int n = 0; n < 40 && !d && !t; n++) begin
			@(posedge i_clock);
			#1;
			d = o_done === 1'h1;
			t = o_trap_illegal === 1'h1;
		end
		chk("trap", {31'h0, tr}, {31'h0, t});
		if (!d && !t) chk("done", 32'h1, 32'h0);
	endtask : run
	task t_super;
		run(OP_SET_CONFIG, 4'h0, SIZE_DOUBLE, 32'h0000_035a, 1'h0);
		chk("config", 32'h5a, {24'h0, o_config});
		run(OP_LOAD_DEDICATED, DREG_INT_BASE, SIZE_DOUBLE, 32'h1234_5678, 1'h0);
		chk("int_base", 32'h1234_5678, o_int_base);
		run(OP_STORE_DEDICATED, DREG_INT_BASE, SIZE_DOUBLE, 32'h0, 1'h0);
		chk("store", 32'h1234_5678, o_result);
		run(OP_SET_STATUS, 4'h0, SIZE_BYTE, 32'h0000_0381, 1'h0);
		run(OP_CLEAR_STATUS, 4'h0, SIZE_BYTE, 32'h0000_0301, 1'h0);
		chk("status", 32'h80, {16'h0, o_status});
		run(OP_DIAGNOSE, 4'h0, SIZE_BYTE, 32'h0, 1'h0);
		chk("next_pc", i_pc, o_next_pc);
		$display("supervisor test done");
	endtask : t_super
	task t_user;
		run(OP_SET_STATUS, 4'h0, SIZE_WORD, 32'h0000_0100, 1'h0);
		chk("status", 32'h180, {16'h0, o_status});
		run(OP_SET_CONFIG, 4'h0, SIZE_DOUBLE, 32'h0000_0033, 1'h1);
		run(OP_LOAD_DEDICATED, DREG_STATUS, SIZE_WORD, 32'h0, 1'h1);
		run(OP_LOAD_DEDICATED, DREG_INT_BASE, SIZE_DOUBLE, 32'h0, 1'h1);
		run(OP_STORE_DEDICATED, DREG_STATUS, SIZE_WORD, 32'h0, 1'h1);
		run(OP_STORE_DEDICATED, DREG_INT_BASE, SIZE_DOUBLE, 32'h0, 1'h1);
		run(OP_STORE_DEDICATED, DREG_USER_SP, SIZE_DOUBLE, 32'h0, 1'h0);
		run(OP_LOAD_DEDICATED, DREG_FRAME_PTR, SIZE_DOUBLE, 32'h0, 1'h0);
		run(OP_SET_STATUS, 4'h0, SIZE_DOUBLE, 32'h0000_0001, 1'h1);
		run(OP_CLEAR_STATUS, 4'h0, SIZE_WORD, 32'h0000_0100, 1'h1);
		chk("config", 32'h5a, {24'h0, o_config});
		chk("int_base", 32'h1234_5678, o_int_base);
		run(OP_CLEAR_STATUS, 4'h0, SIZE_BYTE, 32'h0000_0180, 1'h0);
		chk("status", 32'h100, {16'h0, o_status});
		$display("user test done");
	endtask : t_user
	task bitop(input op_t op, input logic [4:0] b, input logic [31:0] rd, input logic fl,
		input logic [31:0] wd, input logic lk);
		@(posedge i_clock);
		i_bit_index <= b;
		i_mem_rdata <= rd;
		run(op, 4'h0, SIZE_DOUBLE, 32'h0, 1'h0);
		chk("flag", {31'h0, fl}, {31'h0, o_flag});
		chk("wdata", wd, wdata);
		chk("lock", {31'h0, lk}, {31'h0, lock_seen});
	endtask : bitop
	task t_bits;
		bitop(OP_ATOMIC_SET, 5'h05, 32'h0000_0000, 1'h0, 32'h0000_0020, 1'h1);
		bitop(OP_ATOMIC_SET, 5'h1f, 32'h8000_0001, 1'h1, 32'h8000_0001, 1'h1);
		bitop(OP_ATOMIC_CLEAR, 5'h1f, 32'hffff_ffff, 1'h1, 32'h7fff_ffff, 1'h1);
		bitop(OP_TEST_INVERT, 5'h04, 32'h0000_00f0, 1'h1, 32'h0000_00e0, 1'h0);
		bitop(OP_TEST_INVERT, 5'h00, 32'h0000_00f0, 1'h0, 32'h0000_00f1, 1'h0);
		$display("bit test done");
	endtask : t_bits
	task pix(input logic [31:0] origin_bit_address, input logic [15:0] x, input logic [15:0] y);
		@(posedge i_clock);
		i_x <= x;
		i_y <= y;
		i_pitch_bits <= 32'h0000_03e8;
		run(OP_PIXEL_ADDR, 4'h0, SIZE_DOUBLE, origin_bit_address, 1'h0);
		chk("pixel", origin_bit_address + {16'h0, y} * 32'h0000_03e8 + {16'h0, x}, o_result);
	endtask : pix
	task flt(input op_t op, input logic [31:0] v, input logic [31:0] e);
		run(op, 4'h0, SIZE_DOUBLE, v, 1'h0);
		chk("float", e, o_result);
	endtask : flt
	task t_misc;
		pix(32'h0000_1003, 16'h0000, 16'h0000);
		pix(32'h0000_1003, 16'h0001, 16'h0000);
		pix(32'h0000_1003, 16'h0000, 16'h0001);
		pix(32'h0000_1003, 16'h0007, 16'h0003);
		flt(OP_FLOAT_TRUNC, 32'hc020_0000, 32'hffff_fffe);
		flt(OP_FLOAT_FLOOR, 32'hc020_0000, 32'hffff_fffd);
		flt(OP_FLOAT_TRUNC, 32'h4020_0000, 32'h0000_0002);
		flt(OP_FLOAT_FLOOR, 32'h4020_0000, 32'h0000_0002);
		run(OP_SET_STATUS, 4'h0, SIZE_BYTE, 32'h0000_0020, 1'h0);
		@(posedge i_clock);
		i_block_field_opts <= 4'h4;
		run(OP_BLOCK_OPTS, 4'h0, SIZE_DOUBLE, 32'h0000_0002, 1'h0);
		chk("block_opts", 32'h7, {28'h0, o_block_opts});
		$display("pixel float block test done");
	endtask : t_misc
	initial begin
		reset();
		t_super();
		t_user();
		reset();
		t_bits();
		t_misc();
		end_of_test();
	end
endmodule : test_priv_ops_core
`default_nettype wire
